// ===== hw/rdio_ctrl.sv
`timescale 1ns/10ps
// What this block does
// - program-select output high when nothing runs and nothing is paused
// - with several slots, high only if every slot is idle
// - slots set to always-running or error-start are ignored for program-select
// - rising fault-clear edge leaves the error state
// - error output high while an error exists
// - rising power-on request edge switches drive power on
// - power-on switches every configured mechanism on together
// - powered output high while any mechanism has power
// - power-off request level switches all mechanisms off
// - power-on requests ignored while power-off request is active
// - inhibit output shows when drive power cannot be switched on
// - entering auto without permit raises E5010 and blocks auto
// - permit output follows the current permit state
// - cycle-stop edge starts stop; active output until stop completes
// - freeze input level sets or releases freeze for all mechanisms
// - freeze only changes while every slot is program-selectable
// - freeze status high when any mechanism is frozen
// - frozen: arm motion inhibited, program execution continues
// - retreat request edge starts joint move to the retreat pose
// - retreat move speed taken from current speed override
// - retreat-in-progress output high for the whole retreat move
module rdio_ctrl
    import rdio_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_n_i,

    // sequencer pins
    input  wire logic                  fault_clear_in_i,
    input  wire logic                  drive_power_on_req_i,
    input  wire logic                  drive_power_off_req_i,
    input  wire logic                  auto_run_permit_i,
    input  wire logic                  cycle_stop_req_i,
    input  wire logic                  motion_freeze_i,
    input  wire logic                  safe_retreat_req_i,

    // task slot state from the controller core
    input  wire logic [NUM_SLOTS-1:0]  slot_running_i,
    input  wire logic [NUM_SLOTS-1:0]  slot_paused_i,
    input  rdio_slot_cond_e            slot_start_condition_i [NUM_SLOTS],

    // controller core events and settings
    input  wire logic                  error_event_i,
    input  wire logic                  auto_mode_enter_i,
    input  wire logic                  auto_mode_i,
    input  wire logic [NUM_MECH-1:0]   mech_present_i,
    input  wire logic                  power_block_i,
    input  wire logic                  cycle_stop_done_i,
    input  wire logic                  retreat_done_i,
    input  wire logic [OVR_W-1:0]      speed_override_i,

    // status outputs to the sequencer
    output logic                       prog_select_ok_o,
    output logic                       error_o,
    output logic                       drive_powered_o,
    output logic                       power_on_inhibit_o,
    output logic                       auto_permitted_o,
    output logic                       cycle_stop_active_o,
    output logic                       freeze_status_o,
    output logic                       retreat_active_o,

    // commands to the controller core
    output logic [ERR_CODE_W-1:0]      error_code_o,
    output logic                       auto_blocked_o,
    output logic [NUM_MECH-1:0]        drive_power_en_o,
    output logic                       cycle_stop_start_o,
    output logic [NUM_MECH-1:0]        freeze_mech_o,
    output logic                       arm_motion_en_o,
    output logic                       retreat_start_o,
    output logic [OVR_W-1:0]           retreat_speed_o
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [NUM_PINS-1:0]   sync1;
        logic [NUM_PINS-1:0]   sync2;
        logic [NUM_PINS-1:0]   prev;
        logic                  err;
        logic [ERR_CODE_W-1:0] err_code;
        logic                  auto_blk;
        logic [NUM_MECH-1:0]   pwr;
        logic                  cyc;
        logic                  cyc_pulse;
        logic [NUM_MECH-1:0]   frz;
        logic                  ret;
        logic                  ret_pulse;
        logic [OVR_W-1:0]      ret_speed;
    } rdio_state_s;

    localparam rdio_state_s STATE_RST = '{
        sync1:     PINS_RST,
        sync2:     PINS_RST,
        prev:      PINS_RST,
        err:       1'b0,
        err_code:  ERR_CODE_NONE,
        auto_blk:  1'b0,
        pwr:       MECH_RST,
        cyc:       1'b0,
        cyc_pulse: 1'b0,
        frz:       MECH_RST,
        ret:       1'b0,
        ret_pulse: 1'b0,
        ret_speed: OVR_RST
    };

    rdio_state_s state_ff;
    rdio_state_s nxt_state;

    logic [NUM_PINS-1:0]  pins_raw;
    logic [NUM_PINS-1:0]  rise;
    logic [NUM_SLOTS-1:0] slot_busy;
    logic                 all_idle;
    logic                 pwr_off_lvl;
    logic                 inhibit;
    logic                 auto_fail;

    // ****************************************
    // pin gathering and edge detection
    // ****************************************
    assign pins_raw[PIN_FAULT_CLR] = fault_clear_in_i;
    assign pins_raw[PIN_PWR_ON]    = drive_power_on_req_i;
    assign pins_raw[PIN_PWR_OFF]   = drive_power_off_req_i;
    assign pins_raw[PIN_AUTO_OK]   = auto_run_permit_i;
    assign pins_raw[PIN_CYC_STOP]  = cycle_stop_req_i;
    assign pins_raw[PIN_FREEZE]    = motion_freeze_i;
    assign pins_raw[PIN_RETREAT]   = safe_retreat_req_i;

    // one pulse per inactive-to-active transition
    assign rise = state_ff.sync2 & ~state_ff.prev;

    // ****************************************
    // program-select evaluation
    // ****************************************
    generate
        for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
            // always-running and error-start slots never count
            assign slot_busy[s] = (slot_start_condition_i[s] == SLOT_START) &&
                                  (slot_running_i[s] || slot_paused_i[s]);
        end
    endgenerate

    assign all_idle = ~|slot_busy;

    // ****************************************
    // power interlock
    // ****************************************
    assign pwr_off_lvl = state_ff.sync2[PIN_PWR_OFF];
    assign inhibit     = pwr_off_lvl | power_block_i;
    assign auto_fail   = auto_mode_enter_i & ~state_ff.sync2[PIN_AUTO_OK];

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        nxt_state = state_ff;

        // ****************************************
        // pin synchroniser
        // ****************************************
        // two-stage synchroniser, then edge history
        // only the second stage is read by logic, never the first
        nxt_state.sync1 = pins_raw;
        nxt_state.sync2 = state_ff.sync1;
        nxt_state.prev  = state_ff.sync2;

        // ****************************************
        // error state
        // ****************************************
        // error: a new error wins over a clear in the same cycle
        // the code names the latest cause; a clear empties it
        if (rise[PIN_FAULT_CLR]) begin
            nxt_state.err      = 1'b0;
            nxt_state.err_code = ERR_CODE_NONE;
        end
        if (error_event_i) begin
            nxt_state.err      = 1'b1;
            nxt_state.err_code = ERR_CODE_EXT;
        end
        if (auto_fail) begin
            nxt_state.err      = 1'b1;
            nxt_state.err_code = ERR_CODE_NO_AUTO;
        end

        // ****************************************
        // automatic-run interlock
        // ****************************************
        // auto block holds until auto mode is left
        // a permit that arrives later does not lift the block
        if (auto_fail) begin
            nxt_state.auto_blk = 1'b1;
        end else if (!auto_mode_i) begin
            nxt_state.auto_blk = 1'b0;
        end

        // ****************************************
        // drive power
        // ****************************************
        // drive power: off level dominates and masks on requests
        // an on edge seen while inhibited is dropped, not queued
        // mechanisms not present are never switched on
        if (pwr_off_lvl) begin
            nxt_state.pwr = MECH_RST;
        end else if (rise[PIN_PWR_ON] && !inhibit) begin
            nxt_state.pwr = state_ff.pwr | mech_present_i;
        end

        // ****************************************
        // cycle stop
        // ****************************************
        // cycle stop: start wins over a completion in the same cycle
        // a second edge during a running stop is ignored
        // the start pulse to the core lasts one cycle
        nxt_state.cyc_pulse = 1'b0;
        if (rise[PIN_CYC_STOP] && !state_ff.cyc) begin
            nxt_state.cyc       = 1'b1;
            nxt_state.cyc_pulse = 1'b1;
        end else if (cycle_stop_done_i) begin
            nxt_state.cyc = 1'b0;
        end

        // ****************************************
        // motion freeze
        // ****************************************
        // freeze follows the pin level only while all slots are idle
        // a level change while a slot runs waits until the slots go idle
        // all mechanisms share one freeze state
        if (all_idle) begin
            nxt_state.frz = {NUM_MECH{state_ff.sync2[PIN_FREEZE]}};
        end

        // ****************************************
        // safe retreat
        // ****************************************
        // safe retreat: speed captured from override at start
        // later override changes do not bend a move in flight
        // the start pulse to the core lasts one cycle
        nxt_state.ret_pulse = 1'b0;
        if (rise[PIN_RETREAT] && !state_ff.ret) begin
            nxt_state.ret       = 1'b1;
            nxt_state.ret_pulse = 1'b1;
            nxt_state.ret_speed = speed_override_i;
        end else if (retreat_done_i) begin
            nxt_state.ret = 1'b0;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= STATE_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // program select is combinational from the slot state
    assign prog_select_ok_o    = all_idle;

    // error state and its cause
    assign error_o             = state_ff.err;
    assign error_code_o        = state_ff.err_code;

    // drive power and its interlock
    assign drive_power_en_o    = state_ff.pwr;
    assign drive_powered_o     = |state_ff.pwr;
    assign power_on_inhibit_o  = inhibit;

    // automatic-run permit and block
    assign auto_permitted_o    = state_ff.sync2[PIN_AUTO_OK];
    assign auto_blocked_o      = state_ff.auto_blk;

    // cycle stop
    assign cycle_stop_active_o = state_ff.cyc;
    assign cycle_stop_start_o  = state_ff.cyc_pulse;

    // motion freeze
    assign freeze_mech_o       = state_ff.frz;
    assign freeze_status_o     = |state_ff.frz;
    // frozen arm stays still; program flow is not gated here
    assign arm_motion_en_o     = ~|state_ff.frz;

    // safe retreat
    assign retreat_active_o    = state_ff.ret;
    assign retreat_start_o     = state_ff.ret_pulse;
    assign retreat_speed_o     = state_ff.ret_speed;

endmodule

// ===== hw/rdio_pkg.sv
package rdio_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int NUM_SLOTS  = 4;
    localparam int NUM_MECH   = 2;
    localparam int OVR_W      = 8;
    localparam int ERR_CODE_W = 16;
    localparam int NUM_PINS   = 7;

    // ****************************************
    // synchronised pin positions
    // ****************************************
    localparam int PIN_FAULT_CLR = 0;
    localparam int PIN_PWR_ON    = 1;
    localparam int PIN_PWR_OFF   = 2;
    localparam int PIN_AUTO_OK   = 3;
    localparam int PIN_CYC_STOP  = 4;
    localparam int PIN_FREEZE    = 5;
    localparam int PIN_RETREAT   = 6;

    // ****************************************
    // error codes and reset values
    // ****************************************
    localparam logic [ERR_CODE_W-1:0] ERR_CODE_NONE    = 16'h0000;
    localparam logic [ERR_CODE_W-1:0] ERR_CODE_EXT     = 16'h0001;
    localparam logic [ERR_CODE_W-1:0] ERR_CODE_NO_AUTO = 16'h1392;
    localparam logic [NUM_PINS-1:0]   PINS_RST         = 7'h00;
    localparam logic [NUM_MECH-1:0]   MECH_RST         = 2'h0;
    localparam logic [OVR_W-1:0]      OVR_RST          = 8'h00;

    // ****************************************
    // slot start condition
    // ****************************************
    typedef enum logic [1:0] {
        SLOT_START,
        SLOT_ALWAYS,
        SLOT_ERROR
    } rdio_slot_cond_e;

endpackage

// ===== sim/rdio_ctrl_checker.sv
`timescale 1ns/10ps
module rdio_ctrl_checker
    import rdio_pkg::*;
(
    // clock, reset and inputs
    input wire logic            clk_sys_i,
    input wire logic            rst_n_i,
    input wire logic [3:0]      slot_running_i,
    input wire logic [3:0]      slot_paused_i,
    input rdio_slot_cond_e      slot_start_condition_i [NUM_SLOTS],
    input wire logic            error_event_i,
    input wire logic            auto_mode_enter_i,
    input wire logic            drive_power_on_req_i,
    input wire logic [1:0]      mech_present_i,
    input wire logic            power_block_i,
    input wire logic            cycle_stop_done_i,
    input wire logic [7:0]      speed_override_i,
    // outputs
    input wire logic            prog_select_ok_o,
    input wire logic            error_o,
    input wire logic            auto_permitted_o,
    input wire logic [15:0]     error_code_o,
    input wire logic            auto_blocked_o,
    input wire logic            power_on_inhibit_o,
    input wire logic [1:0]      drive_power_en_o,
    input wire logic            drive_powered_o,
    input wire logic [1:0]      freeze_mech_o,
    input wire logic            cycle_stop_active_o,
    input wire logic            cycle_stop_start_o,
    input wire logic            retreat_start_o,
    input wire logic            retreat_active_o,
    input wire logic [7:0]      retreat_speed_o
);
    logic idle_all;

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    // only start-condition slots count
    always_comb begin
        idle_all = 1'h1;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (slot_start_condition_i[i] == SLOT_START && (slot_running_i[i] | slot_paused_i[i])) begin
                idle_all = 1'h0;
            end
        end
    end

    prog_ok_a: assert property (prog_select_ok_o == idle_all)
        else $error("program select output wrong");
    err_set_a: assert property (error_event_i |=> error_o)
        else $error("error not raised");
    auto_fail_a: assert property ((!auto_permitted_o)[*2]
        ##0 (auto_mode_enter_i && !error_event_i)
        |=> error_code_o == ERR_CODE_NO_AUTO && auto_blocked_o && error_o)
        else $error("auto entry without permit not blocked");
    pwr_on_a: assert property ($rose(drive_power_on_req_i) ##0 (!power_on_inhibit_o)[*5]
        |-> (drive_power_en_o & mech_present_i) == mech_present_i)
        else $error("drive power not switched on");
    pwr_off_a: assert property (power_on_inhibit_o && !power_block_i |=> drive_power_en_o == 2'h0)
        else $error("drive power not switched off");
    powered_or_a: assert property (drive_powered_o == |drive_power_en_o)
        else $error("powered status wrong");
    freeze_hold_a: assert property (!prog_select_ok_o |=> $stable(freeze_mech_o))
        else $error("freeze changed while slots busy");
    retreat_go_a: assert property (retreat_start_o |-> retreat_active_o
        && retreat_speed_o == $past(speed_override_i) ##1 !retreat_start_o)
        else $error("retreat start wrong");
    stop_end_a: assert property (cycle_stop_done_i && cycle_stop_active_o |=> !cycle_stop_active_o)
        else $error("cycle stop not ended");
    stop_start_a: assert property (cycle_stop_start_o
        |-> cycle_stop_active_o ##1 !cycle_stop_start_o)
        else $error("cycle stop start pulse wrong");

    retreat_c: cover property (retreat_start_o);
    blocked_c: cover property (auto_blocked_o);
    powered_c: cover property ($rose(drive_powered_o));
endmodule

bind rdio_ctrl rdio_ctrl_checker rdio_ctrl_checker_inst (.clk_sys_i, .rst_n_i, .slot_running_i,
    .slot_paused_i, .slot_start_condition_i, .error_event_i, .auto_mode_enter_i,
    .drive_power_on_req_i, .mech_present_i, .power_block_i, .cycle_stop_done_i,
    .speed_override_i, .prog_select_ok_o, .error_o, .auto_permitted_o, .error_code_o,
    .auto_blocked_o, .power_on_inhibit_o, .drive_power_en_o, .drive_powered_o,
    .freeze_mech_o, .cycle_stop_active_o, .cycle_stop_start_o, .retreat_start_o, .retreat_active_o,
    .retreat_speed_o);

// ===== sim/rdio_seq_model.sv
`timescale 1ns/10ps
module rdio_seq_model
    import rdio_pkg::*;
(
    // clock and bench commands
    input  wire logic                clk_sys_i,
    input  wire logic                prog_select_ok_i,
    input  wire logic [NUM_PINS-1:0] pulse_i,
    input  wire logic [NUM_PINS-1:0] level_i,
    // pins to the controller
    output logic      [NUM_PINS-1:0] pins_o
);
    logic [1:0] hold_ff [NUM_PINS] = '{default: 2'h0};
    logic       freeze_ff          = 1'h0;

    // edge requests stay high three cycles
    always @(posedge clk_sys_i) begin
        for (int i = 0; i < NUM_PINS; i++) begin
            hold_ff[i] <= pulse_i[i] ? 2'h3 : hold_ff[i] - {1'h0, hold_ff[i] != 2'h0};
        end
        if (prog_select_ok_i) begin
            freeze_ff <= level_i[PIN_FREEZE];
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            pins_o[i] = level_i[i] | (hold_ff[i] != 2'h0);
        end
        pins_o[PIN_FREEZE] = freeze_ff;
    end
endmodule

// ===== sim/tb_robot_dedicated_io_control.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_robot_dedicated_io_control
    import rdio_pkg::*;
;
    logic clk_sys_i = 1'h0, rst_n_i = 1'h0;
    logic [3:0] slot_running_i = '0, slot_paused_i = '0;
    rdio_slot_cond_e slot_start_condition_i [NUM_SLOTS] = '{default: SLOT_START};
    logic error_event_i = 1'h0, auto_mode_enter_i = 1'h0, auto_mode_i = 1'h0, power_block_i = 1'h0;
    logic cycle_stop_done_i = 1'h0, retreat_done_i = 1'h0;
    logic [1:0] mech_present_i = 2'h3, drive_power_en_o, freeze_mech_o;
    logic [7:0] speed_override_i = 8'h40, retreat_speed_o;
    logic [6:0] pulse = '0, level = '0, pins;
    logic prog_select_ok_o, error_o, drive_powered_o, power_on_inhibit_o, auto_permitted_o;
    logic cycle_stop_active_o, freeze_status_o, retreat_active_o, auto_blocked_o;
    logic cycle_stop_start_o, arm_motion_en_o, retreat_start_o;
    logic [15:0] error_code_o;
    int fail_count = 0, cmp_count = 0, cyc = 0;

    initial forever #2.5 clk_sys_i = ~clk_sys_i;

    rdio_seq_model rdio_seq_model_inst (.clk_sys_i, .prog_select_ok_i(prog_select_ok_o),
        .pulse_i(pulse), .level_i(level), .pins_o(pins));
    rdio_ctrl rdio_ctrl_inst (.clk_sys_i, .rst_n_i, .fault_clear_in_i(pins[PIN_FAULT_CLR]),
        .drive_power_on_req_i(pins[PIN_PWR_ON]), .drive_power_off_req_i(pins[PIN_PWR_OFF]),
        .auto_run_permit_i(pins[PIN_AUTO_OK]), .cycle_stop_req_i(pins[PIN_CYC_STOP]),
        .motion_freeze_i(pins[PIN_FREEZE]), .safe_retreat_req_i(pins[PIN_RETREAT]),
        .slot_running_i, .slot_paused_i, .slot_start_condition_i, .error_event_i,
        .auto_mode_enter_i, .auto_mode_i, .mech_present_i, .power_block_i, .cycle_stop_done_i,
        .retreat_done_i, .speed_override_i, .prog_select_ok_o, .error_o, .drive_powered_o,
        .power_on_inhibit_o, .auto_permitted_o, .cycle_stop_active_o, .freeze_status_o,
        .retreat_active_o, .error_code_o, .auto_blocked_o, .drive_power_en_o,
        .cycle_stop_start_o, .freeze_mech_o, .arm_motion_en_o, .retreat_start_o,
        .retreat_speed_o);

    function automatic logic exp_prog();
        exp_prog = 1'h1;
        foreach (slot_start_condition_i[i])
            if (slot_start_condition_i[i] == SLOT_START && (slot_running_i[i] | slot_paused_i[i]))
                exp_prog = 1'h0;
    endfunction

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic pin_pulse(input int p);
        @(posedge clk_sys_i) pulse[p] <= 1'h1;
        @(posedge clk_sys_i) pulse[p] <= 1'h0;
        repeat (6) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask

    task automatic set_lvl(input int p, input logic v);
        @(posedge clk_sys_i) level[p] <= v;
        repeat (6) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask

    task automatic core_pulse(input int k);
        @(posedge clk_sys_i);
        {retreat_done_i, cycle_stop_done_i, error_event_i, auto_mode_enter_i} <= 4'h1 << k;
        @(posedge clk_sys_i) {retreat_done_i, cycle_stop_done_i, error_event_i, auto_mode_enter_i} <= 4'h0;
        @(negedge clk_sys_i);
    endtask

    // cuts a hang short
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            finish_test();
        end
    end

    initial begin
        void'($urandom(32'h0641));
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'h1;
        repeat (24) begin
            @(posedge clk_sys_i);
            slot_running_i <= 4'($urandom());
            slot_paused_i <= 4'($urandom());
            foreach (slot_start_condition_i[i]) slot_start_condition_i[i] <= rdio_slot_cond_e'($urandom_range(2, 0));
            @(negedge clk_sys_i) `CHK("prog_select_ok_o", exp_prog(), prog_select_ok_o)
        end
        @(posedge clk_sys_i) {slot_running_i, slot_paused_i} <= 8'h00;
        $display("test slots done");
        set_lvl(PIN_FREEZE, 1'h1);
        `CHK("freeze", 4'he, {freeze_mech_o, freeze_status_o, arm_motion_en_o})
        set_lvl(PIN_FREEZE, 1'h0);
        `CHK("freeze", 4'h1, {freeze_mech_o, freeze_status_o, arm_motion_en_o})
        $display("test freeze done");
        @(posedge clk_sys_i) mech_present_i <= 2'($urandom_range(3, 1));
        pin_pulse(PIN_PWR_ON);
        `CHK("drive_power_en_o", mech_present_i, drive_power_en_o)
        `CHK("drive_powered_o", 1'h1, drive_powered_o)
        set_lvl(PIN_PWR_OFF, 1'h1);
        `CHK("power off", 4'h1, {drive_power_en_o, drive_powered_o, power_on_inhibit_o})
        pin_pulse(PIN_PWR_ON);
        `CHK("drive_power_en_o", 2'h0, drive_power_en_o)
        @(posedge clk_sys_i) power_block_i <= 1'h1;
        set_lvl(PIN_PWR_OFF, 1'h0);
        pin_pulse(PIN_PWR_ON);
        `CHK("inhibit", 3'h1, {drive_power_en_o, power_on_inhibit_o})
        @(posedge clk_sys_i) power_block_i <= 1'h0;
        $display("test power done");
        `CHK("auto_permitted_o", 1'h0, auto_permitted_o)
        @(posedge clk_sys_i) auto_mode_i <= 1'h1;
        core_pulse(0);
        `CHK("auto fail", {error_o, auto_blocked_o, error_code_o}, {2'h3, ERR_CODE_NO_AUTO})
        pin_pulse(PIN_FAULT_CLR);
        `CHK("error_o", 1'h0, error_o)
        core_pulse(1);
        `CHK("error_o", 1'h1, error_o)
        `CHK("error_code_o", ERR_CODE_EXT, error_code_o)
        pin_pulse(PIN_FAULT_CLR);
        `CHK("error_o", 1'h0, error_o)
        @(posedge clk_sys_i) auto_mode_i <= 1'h0;
        set_lvl(PIN_AUTO_OK, 1'h1);
        `CHK("auto_permitted_o", 1'h1, auto_permitted_o)
        $display("test error done");
        @(posedge clk_sys_i) speed_override_i <= 8'($urandom());
        for (int k = 0; k < 2; k++) begin
            pin_pulse(k ? PIN_RETREAT : PIN_CYC_STOP);
            `CHK("move active", 1'h1, k ? retreat_active_o : cycle_stop_active_o)
            core_pulse(2 + k);
            `CHK("move idle", 2'h0, {retreat_active_o, cycle_stop_active_o})
        end
        `CHK("retreat_speed_o", speed_override_i, retreat_speed_o)
        $display("test motion done");
        finish_test();
    end
endmodule
